// *** logic/ivp_base_calc.sv ***
// Boot section base and reset address from the fuses
`timescale 1ns/1ps
`default_nettype none
module ivp_base_calc
   import ivp_pkg::*;
(
   // Fuses
   input  wire ivp_fuse_s        fuses,
   // Addresses
   output logic [IVP_AW-1:0]     boot_base,
   output logic [IVP_AW-1:0]     reset_addr
);
   logic [IVP_AW-1:0] boot_words; // Boot section length

   // Size table lookup
   always_comb begin
      unique case (fuses.boot_size_fuses)
         2'h0: boot_words = IVP_BOOT_W0;
         2'h1: boot_words = IVP_BOOT_W1;
         2'h2: boot_words = IVP_BOOT_W2;
         default: boot_words = IVP_BOOT_W3;
      endcase
   end

   // Boot section sits at the top of flash
   assign boot_base  = IVP_FLASH_TOP - boot_words;
   // Programmed fuse moves reset into the boot section
   assign reset_addr = fuses.boot_reset_fuse ? '0 : boot_base;
endmodule
`default_nettype wire

// *** logic/ivp_pkg.sv ***
// Package for the interrupt vector placement block: offsets, fields, timing
// Notes on behaviour
// - Select clear: vectors at flash start
// - Select set: vectors at boot section start
// - Boot base follows boot size fuses
// - Select changes only while enable active
// - Enable clears after four cycles or select write
// - Interrupts blocked from enable until after next instruction
// - No select write: interrupts blocked four cycles
// - Global interrupt flag left untouched
// - Boot vectors plus app lock: block in application
// - App vectors plus boot lock: block in boot
// - Fuse unprogrammed: reset at zero
// - Fuse programmed: reset at boot base
// - Both set: reset then vectors at boot base
package ivp_pkg;
   // Register byte offsets
   localparam logic [7:0] IVP_OFS_CTRL   = 8'h00;
   localparam logic [7:0] IVP_OFS_STATUS = 8'h04;
   // Control register field positions
   localparam int IVP_BIT_CHANGE_EN = 0;
   localparam int IVP_BIT_SELECT    = 1;
   localparam logic [7:0] IVP_CTRL_RESET = 8'h00;
   // Timing: change window is four core cycles
   localparam int IVP_WINDOW_CYCLES = 4;
   localparam logic [2:0] IVP_WINDOW_CNT = 3'h4;
   // Tail count of one covers the instruction after the select write
   localparam logic [1:0] IVP_TAIL_CNT = 2'h1;
   // Word addresses
   localparam int IVP_AW = 13;
   localparam logic [IVP_AW-1:0] IVP_FLASH_TOP = 13'h2000;
   localparam logic [IVP_AW-1:0] IVP_VEC_STEP  = 13'h0002;
   // Boot sizes in words, index is boot size fuse code (programmed = 0)
   localparam logic [IVP_AW-1:0] IVP_BOOT_W0 = 13'h0400;
   localparam logic [IVP_AW-1:0] IVP_BOOT_W1 = 13'h0200;
   localparam logic [IVP_AW-1:0] IVP_BOOT_W2 = 13'h0100;
   localparam logic [IVP_AW-1:0] IVP_BOOT_W3 = 13'h0080;
   // Twenty interrupt sources; the last one sits at base plus 0x28
   localparam int IVP_NSRC = 20;
   // Fuse and lock settings
   typedef struct packed {
      logic       boot_reset_fuse;        // 0 = programmed
      logic [1:0] boot_size_fuses;
      logic       app_section_boot_lock;  // 0 = programmed
      logic       boot_section_self_lock; // 0 = programmed
   } ivp_fuse_s;
endpackage

// *** logic/ivp_top.sv ***
// Interrupt vector placement controller with an AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ivp_top
   import ivp_pkg::*;
(
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic                 hready,
   input  wire logic [31:0]          hwdata,
   output logic [31:0]               hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   // Fuses, static configuration
   input  wire ivp_fuse_s            fuses,
   // Core status
   input  wire logic                 global_irq_enable,
   input  wire logic                 exec_in_boot,
   input  wire logic                 instr_done,
   // Results
   output logic                      irq_accept_en,
   output logic                      irq_block,
   output logic [IVP_AW-1:0]         vector_base,
   output logic [IVP_AW-1:0]         reset_address,
   output logic [IVP_AW-1:0]         external_irq_zero_vector,
   output logic [IVP_AW-1:0]         external_irq_one_vector,
   output logic [IVP_AW-1:0]         store_program_ready_vector
);
   // Bus address phase capture
   logic       wr_pend_q;    // Write data phase pending
   logic       rd_pend_q;    // Read data phase pending
   logic [7:0] addr_q;       // Captured offset
   logic       sel_q;        // Vector select state
   logic       sel_d;
   logic       ce_q;         // Change enable state
   logic       ce_d;
   logic [2:0] ce_cnt_q;     // Cycles left in change window
   logic [2:0] ce_cnt_d;
   logic [1:0] tail_q;       // Instructions left before unblocking
   logic [1:0] tail_d;
   logic       tail_wait_q;  // Waiting for the instruction after the write
   logic       tail_wait_d;
   logic [IVP_AW-1:0] boot_base;
   logic [IVP_NSRC-1:0][IVP_AW-1:0] vectors;

   // Decode
   wire addr_ph   = hsel & hready & htrans[1];
   wire ctrl_wr   = wr_pend_q & (addr_q == IVP_OFS_CTRL);
   wire wr_ce     = hwdata[IVP_BIT_CHANGE_EN];
   wire wr_sel    = hwdata[IVP_BIT_SELECT];
   // A write with the enable bit set opens the window
   wire open_win  = ctrl_wr & wr_ce & ~ce_q;
   // A write with enable clear during the window commits the select
   wire commit    = ctrl_wr & ~wr_ce & ce_q;
   wire win_end   = ce_q & (ce_cnt_q == 3'h1);
   wire lock_app  = sel_q & ~fuses.app_section_boot_lock & ~exec_in_boot;
   wire lock_boot = ~sel_q & ~fuses.boot_section_self_lock & exec_in_boot;
   wire seq_block = ce_q | tail_wait_q;

   // Bus pipeline registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= addr_ph & hwrite;
         rd_pend_q <= addr_ph & ~hwrite;
         if (addr_ph) begin
            addr_q <= haddr[7:0];
         end
      end
   end

   // Zero wait state slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Next state for select and change enable
   always_comb begin
      sel_d       = sel_q;
      ce_d        = ce_q;
      ce_cnt_d    = ce_cnt_q;
      tail_wait_d = tail_wait_q;
      tail_d      = tail_q;
      if (commit) begin
         // Select only moves inside the window
         sel_d       = wr_sel;
         ce_d        = 1'b0;
         ce_cnt_d    = 3'h0;
         tail_wait_d = 1'b1;
         tail_d      = IVP_TAIL_CNT;
      end else if (open_win) begin
         ce_d     = 1'b1;
         ce_cnt_d = IVP_WINDOW_CNT;
      end else if (win_end) begin
         // Timed out, no select write seen
         ce_d     = 1'b0;
         ce_cnt_d = 3'h0;
      end else if (ce_q) begin
         ce_cnt_d = ce_cnt_q - 3'h1;
      end
      // Hold off until one instruction after the commit completes
      if (tail_wait_q && instr_done) begin
         if (tail_q == 2'h1) begin
            tail_wait_d = 1'b0;
         end
         tail_d = tail_q - 2'h1;
      end
   end

   // Control state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q       <= IVP_CTRL_RESET[IVP_BIT_SELECT];
         ce_q        <= IVP_CTRL_RESET[IVP_BIT_CHANGE_EN];
         ce_cnt_q    <= 3'h0;
         tail_wait_q <= 1'b0;
         tail_q      <= 2'h0;
      end else begin
         sel_q       <= sel_d;
         ce_q        <= ce_d;
         ce_cnt_q    <= ce_cnt_d;
         tail_wait_q <= tail_wait_d;
         tail_q      <= tail_d;
      end
   end

   // Read data, driven combinationally in the data phase; unmapped reads give zero
   wire [31:0] ctrl_rd = {30'h0, sel_q, ce_q};
   wire [31:0] stat_rd = {28'h0, lock_boot | lock_app, tail_wait_q, ce_cnt_q == 3'h0, seq_block};
   always_comb begin
      hrdata = 32'h0;
      if (rd_pend_q && addr_q == IVP_OFS_CTRL) begin
         hrdata = ctrl_rd;
      end else if (rd_pend_q && addr_q == IVP_OFS_STATUS) begin
         hrdata = stat_rd;
      end
   end

   // Interrupt gating leaves the global flag as is, only masks acceptance
   assign irq_block     = seq_block | lock_app | lock_boot;
   assign irq_accept_en = global_irq_enable & ~irq_block;

   // Address generation
   ivp_base_calc u_base (
      .fuses      (fuses),
      .boot_base  (boot_base),
      .reset_addr (reset_address)
   );
   assign vector_base = sel_q ? boot_base : '0;
   ivp_vector_calc u_vec (
      .table_base (vector_base),
      .vectors    (vectors)
   );
   assign external_irq_zero_vector   = vectors[0];
   assign external_irq_one_vector    = vectors[1];
   assign store_program_ready_vector = vectors[IVP_NSRC-1];

   // Checks
   // A commit may close the window early, so length is checked on the counter
   chk_win_len: assert property (@(posedge hclk) disable iff (!hresetn)
      open_win |=> (ce_q && ce_cnt_q == IVP_WINDOW_CNT))
      else $error("change window length wrong");
   chk_win_expire: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce_q && ce_cnt_q == 3'h1 && !commit) |=> !ce_q)
      else $error("change window did not expire");
   chk_win_close: assert property (@(posedge hclk) disable iff (!hresetn)
      commit |=> !ce_q)
      else $error("window did not close on select write");
   chk_sel_guard: assert property (@(posedge hclk) disable iff (!hresetn)
      (!ce_q && !(ctrl_wr && ce_q)) |=> $stable(sel_q))
      else $error("select changed outside window");
   chk_sel_take: assert property (@(posedge hclk) disable iff (!hresetn)
      commit |=> sel_q == $past(wr_sel))
      else $error("select not taken");
   chk_block_win: assert property (@(posedge hclk) disable iff (!hresetn)
      ce_q |-> !irq_accept_en)
      else $error("interrupt accepted in window");
   chk_gie_pass: assert property (@(posedge hclk) disable iff (!hresetn)
      !irq_block |-> irq_accept_en == global_irq_enable)
      else $error("global flag not honoured");
   chk_vec_base: assert property (@(posedge hclk) disable iff (!hresetn)
      vector_base == (sel_q ? boot_base : 13'h0000))
      else $error("vector base wrong");
   chk_vec_step: assert property (@(posedge hclk) disable iff (!hresetn)
      external_irq_one_vector - external_irq_zero_vector == IVP_VEC_STEP)
      else $error("vector spacing wrong");
   chk_reset_addr: assert property (@(posedge hclk) disable iff (!hresetn)
      reset_address == (fuses.boot_reset_fuse ? 13'h0000 : boot_base))
      else $error("reset address wrong");
   chk_lock_app: assert property (@(posedge hclk) disable iff (!hresetn)
      (sel_q && !fuses.app_section_boot_lock && !exec_in_boot) |-> !irq_accept_en)
      else $error("application lock not applied");
   cov_commit:  cover property (@(posedge hclk) disable iff (!hresetn) commit);
   cov_timeout: cover property (@(posedge hclk) disable iff (!hresetn) win_end && !commit);
   cov_lock:    cover property (@(posedge hclk) disable iff (!hresetn) lock_boot);
endmodule
`default_nettype wire

// *** logic/ivp_vector_calc.sv ***
// Per-source vector addresses from the table base
`timescale 1ns/1ps
`default_nettype none
module ivp_vector_calc
   import ivp_pkg::*;
(
   // Table base
   input  wire logic [IVP_AW-1:0] table_base,
   // Vector per source, source 0 is the first external request
   output logic [IVP_NSRC-1:0][IVP_AW-1:0] vectors
);
   genvar g;
   // Each source two words apart, first at base plus two
   for (g = 0; g < IVP_NSRC; g++) begin : g_vec
      localparam logic [IVP_AW-1:0] OFS = IVP_AW'(g + 1) * IVP_VEC_STEP;
      assign vectors[g] = table_base + OFS;
   end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking testbench for the interrupt vector placement block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ivp_pkg::*;
   // Clock, reset and bus master signals
   logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   // Fuses and core status
   ivp_fuse_s         fuses;
   logic              global_irq_enable, exec_in_boot, instr_done, irq_accept_en, irq_block;
   logic [IVP_AW-1:0] vector_base, reset_address, ext0, ext1, spm_vec;
   int                num_errors, check_count;
   // Default fuses: reset fuse and locks unprogrammed, largest boot section
   localparam ivp_fuse_s FUSE_DEF = 5'h13;
   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   ivp_top ivp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fuses(fuses),
      .global_irq_enable(global_irq_enable), .exec_in_boot(exec_in_boot),
      .instr_done(instr_done), .irq_accept_en(irq_accept_en), .irq_block(irq_block),
      .vector_base(vector_base), .reset_address(reset_address),
      .external_irq_zero_vector(ext0), .external_irq_one_vector(ext1),
      .store_program_ready_vector(spm_vec));
   // 20 MHz clock
   always #25 hclk = ~hclk;
   // Verdict and end of run
   task automatic close_out();
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Wait for ready under a bound, capturing read data at that edge
   task automatic wait_rdy(output logic [31:0] d);
      int   n;
      logic r;
      n = 0;
      do begin
         // Sample settled values late in the cycle that ends at the edge
         @(negedge hclk);
         d = hrdata;
         r = hreadyout;
         @(posedge hclk);
         n++;
      end while (r !== 1'b1 && n < 16);
      if (r !== 1'b1) begin
         num_errors++;
         close_out();
      end
   endtask
   // One AHB single transfer; called right after a rising edge
   task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                           output logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy(d);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(d);
   endtask
   // Boot base for a boot size code, in 13-bit word arithmetic
   function automatic logic [IVP_AW-1:0] boot_of(input logic [1:0] c);
      logic [IVP_AW-1:0] w;
      w = (c == 2'h0) ? IVP_BOOT_W0 : (c == 2'h1) ? IVP_BOOT_W1 :
          (c == 2'h2) ? IVP_BOOT_W2 : IVP_BOOT_W3;
      return IVP_FLASH_TOP - w;
   endfunction
   // Every reset and boot size fuse combination against the address map, locks unprogrammed
   task automatic check_map(input logic s);
      logic [IVP_AW-1:0] b, v;
      for (int f = 0; f < 8; f++) begin
         fuses <= {f[2], f[1:0], 2'h3};
         @(posedge hclk);
         b = boot_of(f[1:0]);
         v = s ? b : 13'h0000;
         chk(32'(vector_base), 32'(v));
         chk(32'(reset_address), 32'(f[2] ? 13'h0000 : b));
         chk(32'(ext0), 32'(v + IVP_VEC_STEP));
         chk(32'(ext1), 32'(v + 13'h0004));
         chk(32'(spm_vec), 32'(v + 13'h0028));
      end
      fuses <= FUSE_DEF;
      @(posedge hclk);
   endtask
   // Lock bit blocking by execution section
   task automatic check_lock(input logic s);
      fuses <= s ? 5'h11 : 5'h12;
      for (int i = 0; i < 2; i++) begin
         exec_in_boot <= i[0];
         @(posedge hclk);
         chk(32'(irq_block), 32'(s ^ i[0]));
         chk(32'(irq_accept_en), 32'(!(s ^ i[0])));
      end
      fuses <= FUSE_DEF;
      exec_in_boot <= 1'b0;
      @(posedge hclk);
   endtask
   // Enable opened and left to expire, then a late select write
   task automatic no_write();
      bus_xfer(1'b1, IVP_OFS_CTRL, 32'h00000001, rd);
      #1 chk(32'(irq_accept_en), 32'h0);
      repeat (3) @(posedge hclk);
      #1 chk(32'(irq_block), 32'h1);
      @(posedge hclk);
      #1 chk(32'(irq_block), 32'h0);
      @(posedge hclk);
      bus_xfer(1'b1, IVP_OFS_CTRL, 32'h00000002, rd);
      bus_xfer(1'b0, IVP_OFS_CTRL, 32'h00000000, rd);
      chk(rd, 32'h00000000);
   endtask
   // Full change sequence to select value s, back to back writes
   task automatic move_vectors(input logic s);
      bus_xfer(1'b1, IVP_OFS_CTRL, 32'h00000001, rd);
      bus_xfer(1'b1, IVP_OFS_CTRL, {30'h0, s, 1'b0}, rd);
      repeat (6) @(posedge hclk);
      #1 chk(32'(irq_block), 32'h1);
      @(posedge hclk);
      instr_done <= 1'b1;
      @(posedge hclk);
      instr_done <= 1'b0;
      repeat (2) @(posedge hclk);
      #1 chk(32'(irq_accept_en), 32'h1);
      @(posedge hclk);
      bus_xfer(1'b0, IVP_OFS_CTRL, 32'h00000000, rd);
      chk(rd, {30'h0, s, 1'b0});
   endtask
   // Main sequence
   initial begin
      hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
      hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0; fuses = FUSE_DEF;
      global_irq_enable = 1'b1; exec_in_boot = 1'b0; instr_done = 1'b0;
      num_errors = 0; check_count = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus_xfer(1'b0, IVP_OFS_CTRL, 32'h00000000, rd);
      chk(rd, {24'h000000, IVP_CTRL_RESET});
      check_map(1'b0);
      check_lock(1'b0);
      no_write();
      move_vectors(1'b1);
      check_map(1'b1);
      check_lock(1'b1);
      move_vectors(1'b0);
      bus_xfer(1'b1, 8'h08, 32'hFFFFFFFF, rd);
      bus_xfer(1'b0, 8'h08, 32'h00000000, rd);
      chk(rd, 32'h00000000);
      close_out();
   end
endmodule
`default_nettype wire
